// [dv/ext_cpu_model.sv]
// external processor on port d and the port e strobes
// assumes strobes bit0 read, bit1 write, bit2 select, all low active
`timescale 1ns/1ps
`default_nettype none

module ext_cpu_model (
    input  wire logic       clk,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe_n,
    output logic      [7:0] pd_in,
    output logic      [2:0] pe_in
);
    logic [7:0] bus_drv;
    logic       bus_en;
    // a released bus shows the inverse, so a stale byte never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pd_in[i] = !pd_oe_n[i] ? pd_out[i] : (bus_en ? bus_drv[i] : !bus_drv[i]);
        end
    end
    initial begin
        pe_in = 3'h7;
        bus_en = 1'b0;
        bus_drv = 8'h00;
    end
////////////////////////////////////////////////////////////////
    task automatic write_byte(input logic [7:0] v, input int hold);
        @(posedge clk);
        bus_drv <= v;
        bus_en <= 1'b1;
        repeat (3) @(posedge clk);
        pe_in <= 3'b001;
        repeat (hold) @(posedge clk);
        pe_in <= 3'h7;
        @(posedge clk);
        bus_en <= 1'b0;
    endtask
    task automatic read_byte(output logic [7:0] v, input int hold);
        @(posedge clk);
        pe_in <= 3'b010;
        repeat (hold) @(posedge clk);
        v = pd_in;
        pe_in <= 3'h7;
    endtask
endmodule
`default_nettype wire

// [dv/psp_properties.sv]
// checker on the parallel slave port top ports
// assumes a bind onto parallel_slave_port, one clock, reset low active
`timescale 1ns/1ps
`default_nettype none
`include "psp_cfg.svh"

module psp_properties (
    input wire logic        SYS_CLK,
    input wire logic        RSTN,
    input wire logic        CE,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        IRQ,
    input wire logic [7:0]  PD_OE_N,
    input wire logic [2:0]  PE_IN,
    input wire logic [2:0]  PE_OE_N,
    input wire logic        PE_TTL_SEL
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
////////////////////////////////////////////////////////////////
    a_ack_one_pulse: assert property (ACK_O && CE |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_follows_req: assert property (CE && CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked next cycle");
    a_ack_has_req: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_rdata_lane_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0 && (!WE_I || DAT_O[7:0] == 8'h00))
        else $error("read data outside low lane");
    a_reset_quiet: assert property (!$past(RSTN) |-> !IRQ && !ACK_O && PD_OE_N == 8'hff && !PE_TTL_SEL)
        else $error("outputs not at reset values");
    a_strobes_input: assert property (PE_TTL_SEL |-> PE_OE_N == 3'h7)
        else $error("strobe pins driven in slave mode");
    a_ttl_from_write: assert property ($rose(PE_TTL_SEL) |->
        $past(WE_I && ADR_I == `PSP_OFS_CTRL) || $past(WE_I && ADR_I == `PSP_OFS_CTRL, 2))
        else $error("ttl select without control write");
    a_idle_no_drive: assert property (PE_TTL_SEL && $past(PE_TTL_SEL) && $past(PE_IN[2] | PE_IN[0], 2)
        && $past(PE_IN[2] | PE_IN[0], 3) |-> PD_OE_N == 8'hff)
        else $error("port d driven without read");
    // three samples of a steady read cover both sync depths the note allows
    a_read_drives: assert property (PE_TTL_SEL && $past(PE_TTL_SEL, 3) && $past(PE_IN, 2) == 3'b010
        && $past(PE_IN, 3) == 3'b010 && $past(PE_IN, 4) == 3'b010 |-> PD_OE_N == 8'h00)
        else $error("port d not driven during read");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the parallel slave port
// assumes package, psp_cfg.svh and design compiled first
`timescale 1ns/1ps
`default_nettype none
`include "psp_cfg.svh"

module tb_top;
    typedef struct packed { logic [7:0] adr; logic wr; logic [7:0] wd; logic [7:0] exp; } row_t;
    logic        SYS_CLK, RSTN, CE, CYC_I, STB_I, WE_I, ACK_O, IRQ, PE_TTL_SEL;
    logic [3:0]  SEL_I;
    logic [7:0]  ADR_I, PD_IN, PD_OUT, PD_OE_N, q, d;
    logic [31:0] DAT_I, DAT_O;
    logic [2:0]  PE_IN, PE_OUT, PE_OE_N;
    int          failures, num_checks;
    row_t        rows [0:16] = '{'{8'h08, 1'b0, 8'h00, 8'hff}, '{8'h14, 1'b0, 8'h00, 8'hff},
        '{8'h2c, 1'b0, 8'h00, 8'h7f}, '{8'h18, 1'b0, 8'h00, 8'h00}, '{8'h20, 1'b0, 8'h00, 8'h00},
        '{8'h24, 1'b0, 8'h00, 8'h00}, '{8'h28, 1'b0, 8'h00, 8'h00}, '{8'h1c, 1'b0, 8'h00, 8'h00},
        '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h04, 1'b0, 8'h00, 8'h00}, '{8'h04, 1'b1, 8'ha5, 8'ha5},
        '{8'h2c, 1'b1, 8'h3c, 8'h3c}, '{8'h1c, 1'b1, 8'hff, 8'h3f}, '{8'h30, 1'b1, 8'hff, 8'h00},
        '{8'h18, 1'b1, 8'h0f, 8'h00}, '{8'h14, 1'b1, 8'h07, 8'h07},
        '{8'h10, 1'b1, 8'h05, 8'h05}};

    parallel_slave_port parallel_slave_port_inst (.SYS_CLK, .RSTN, .CE, .CYC_I, .STB_I, .WE_I, .ADR_I,
        .SEL_I, .DAT_I, .DAT_O, .ACK_O, .IRQ, .PD_IN, .PD_OUT, .PD_OE_N, .PE_IN, .PE_OUT, .PE_OE_N, .PE_TTL_SEL);
    ext_cpu_model ext_cpu_model_inst (.clk(SYS_CLK), .pd_out(PD_OUT), .pd_oe_n(PD_OE_N), .pd_in(PD_IN),
        .pe_in(PE_IN));
////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v);
        int n;
        n = 0;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= {24'h0, v};
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        q = DAT_O[7:0];
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        wb(a, 1'b0, 8'h00);
        chk(q, e);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    initial begin
        RSTN = 1'b0;
        CE = 1'b1;
        CYC_I = 1'b0;
        STB_I = 1'b0;
        WE_I = 1'b0;
        SEL_I = 4'h1;
        ADR_I = 8'h00;
        DAT_I = 32'h0;
        repeat (5) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        // last rows also set strobe pins as inputs and the pins digital
        foreach (rows[i]) begin
            if (rows[i].wr) wb(rows[i].adr, 1'b1, rows[i].wd);
            rdc(rows[i].adr, rows[i].exp);
        end
        chk(PE_OUT, 3'h5);
        wb(`PSP_OFS_IRQ_EN, 1'b1, 8'h80);
        wb(`PSP_OFS_CTRL, 1'b1, 8'h10);
        chk(PE_TTL_SEL, 1'b1);
        chk(PE_OE_N, 3'h7);
        ext_cpu_model_inst.write_byte(8'h5a, 5);
        rdc(`PSP_OFS_CTRL, 8'h90);
        chk(IRQ, 1'b1);
        ext_cpu_model_inst.write_byte(8'hc3, 2);
        rdc(`PSP_OFS_CTRL, 8'hb0);
        rdc(`PSP_OFS_PD_PINS, 8'h5a);
        rdc(`PSP_OFS_CTRL, 8'h30);
        wb(`PSP_OFS_CTRL, 1'b1, 8'h10);
        rdc(`PSP_OFS_CTRL, 8'h10);
        wb(`PSP_OFS_IRQ_FLG, 1'b1, 8'h80);
        chk(IRQ, 1'b0);
        wb(`PSP_OFS_IRQ_EN, 1'b1, 8'h00);
        ext_cpu_model_inst.write_byte(8'h11, 5);
        chk(IRQ, 1'b0);
        wb(`PSP_OFS_IRQ_EN, 1'b1, 8'h80);
        chk(IRQ, 1'b1);
        wb(`PSP_OFS_IRQ_FLG, 1'b1, 8'h80);
        chk(IRQ, 1'b0);
        rdc(`PSP_OFS_PD_PINS, 8'h11);
        wb(`PSP_OFS_PD_PINS, 1'b1, 8'ha7);
        chk(PD_OUT, 8'ha7);
        // a write without the low byte lane is acknowledged and ignored
        SEL_I <= 4'h0;
        wb(`PSP_OFS_PD_LAT, 1'b1, 8'h00);
        SEL_I <= 4'h1;
        rdc(`PSP_OFS_PD_LAT, 8'ha7);
        rdc(`PSP_OFS_CTRL, 8'h50);
        ext_cpu_model_inst.read_byte(d, 6);
        chk(d, 8'ha7);
        rdc(`PSP_OFS_CTRL, 8'h10);
        // clock enable low freezes the synchroniser, so this write is never seen
        CE <= 1'b0;
        ext_cpu_model_inst.write_byte(8'h77, 5);
        CE <= 1'b1;
        rdc(`PSP_OFS_CTRL, 8'h10);
        wb(`PSP_OFS_CTRL, 1'b1, 8'h00);
        ext_cpu_model_inst.write_byte(8'h66, 5);
        rdc(`PSP_OFS_CTRL, 8'h00);
        chk(PE_TTL_SEL, 1'b0);
        RSTN <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        rdc(`PSP_OFS_PD_DIR, 8'hff);
        rdc(`PSP_OFS_IRQ_EN, 8'h00);
        rdc(`PSP_OFS_PE_DIR, 8'hff);
        rdc(`PSP_OFS_IRQ_PRI, 8'h7f);
        rdc(`PSP_OFS_ADC_CFG, 8'h00);
        tally_and_finish();
    end
endmodule

bind parallel_slave_port psp_properties psp_properties_inst (.SYS_CLK, .RSTN, .CE, .CYC_I, .STB_I, .WE_I,
    .ADR_I, .DAT_O, .ACK_O, .IRQ, .PD_OE_N, .PE_IN, .PE_OE_N, .PE_TTL_SEL);
`default_nettype wire

// [rtl/parallel_slave_port.sv]
// parallel slave port on port d with port e strobes, wishbone register file
// assumes a classic wishbone master on SYS_CLK and asynchronous external pins
// external data must settle one clock before its strobe, as data and strobes share the synchroniser
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "psp_cfg.svh"

module parallel_slave_port (
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    output logic             IRQ,
    input  wire logic [7:0]  PD_IN,
    output logic      [7:0]  PD_OUT,
    output logic      [7:0]  PD_OE_N,
    input  wire logic [2:0]  PE_IN,
    output logic      [2:0]  PE_OUT,
    output logic      [2:0]  PE_OE_N,
    output logic             PE_TTL_SEL
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    psp_pkg::pins_t pins_raw;
    psp_pkg::pins_t pins;

    assign pins_raw.pe = PE_IN;
    assign pins_raw.pd = PD_IN;

    psp_pin_sync u_sync (
        .clk      (SYS_CLK),
        .rstn     (RSTN),
        .ce       (CE),
        .pins_in  (pins_raw),
        .pins_out (pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    typedef enum logic [3:0] {
        R_PD_PINS,
        R_PD_LAT,
        R_PD_DIR,
        R_PE_PINS,
        R_PE_LAT,
        R_PE_DIR,
        R_CTRL,
        R_ADC,
        R_INTCTL,
        R_IRQ_FLG,
        R_IRQ_EN,
        R_IRQ_PRI,
        R_NONE
    } reg_sel_t;

    function automatic reg_sel_t decode(input logic [7:0] adr);
        reg_sel_t r;
        r = R_NONE;
        case (adr)
            `PSP_OFS_PD_PINS: r = R_PD_PINS;
            `PSP_OFS_PD_LAT:  r = R_PD_LAT;
            `PSP_OFS_PD_DIR:  r = R_PD_DIR;
            `PSP_OFS_PE_PINS: r = R_PE_PINS;
            `PSP_OFS_PE_LAT:  r = R_PE_LAT;
            `PSP_OFS_PE_DIR:  r = R_PE_DIR;
            `PSP_OFS_CTRL:    r = R_CTRL;
            `PSP_OFS_ADC_CFG: r = R_ADC;
            `PSP_OFS_INTCTL:  r = R_INTCTL;
            `PSP_OFS_IRQ_FLG: r = R_IRQ_FLG;
            `PSP_OFS_IRQ_EN:  r = R_IRQ_EN;
            `PSP_OFS_IRQ_PRI: r = R_IRQ_PRI;
            default:          r = R_NONE;
        endcase
        return r;
    endfunction

    // control/status byte; the low nibble is unimplemented and reads zero
    function automatic logic [7:0] status_byte(input psp_pkg::state_t st);
        return {st.input_word_pending, st.output_word_pending,
                st.input_overrun, st.slave_port_enable, 4'h0};
    endfunction

    // register read value; port d pins show the input latch in slave port mode
    function automatic logic [7:0] read_mux(input psp_pkg::state_t st,
                                            input psp_pkg::pins_t  pn,
                                            input reg_sel_t        rs);
        logic [7:0] b;
        b = `PSP_RST_ZERO8;
        case (rs)
            R_PD_PINS: b = st.slave_port_enable ? st.pd_in_latch : pn.pd;
            R_PD_LAT:  b = st.pd_out_latch;
            R_PD_DIR:  b = st.pd_dir;
            R_PE_PINS: b = {5'h00, pn.pe};
            R_PE_LAT:  b = st.pe_out_latch;
            R_PE_DIR:  b = st.pe_dir;
            R_CTRL:    b = status_byte(st);
            R_ADC:     b = {2'b00, st.converter_config_1};
            R_INTCTL:  b = st.interrupt_control;
            R_IRQ_FLG: b = st.irq_flags;
            R_IRQ_EN:  b = st.irq_enables;
            R_IRQ_PRI: b = st.irq_priority;
            default:   b = `PSP_RST_ZERO8;
        endcase
        return b;
    endfunction

    // a transfer needs select and its strobe seen low in the same sample
    function automatic logic pair_low(input logic sel_low, input logic strobe_low);
        logic p;
        p = sel_low & strobe_low;
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    psp_pkg::state_t s_reg;
    psp_pkg::state_t s_next;

    logic     req;
    logic     wr_req;
    logic     rd_req;
    reg_sel_t sel;
    logic     cs;
    logic     rd;
    logic     wr;
    logic     ext_wr_ev;
    logic     ext_rd_ev;
    logic     cpu_rd_in;
    logic     cpu_wr_out;
    logic [7:0] rbyte;
    logic [7:0] wbyte;

    always_comb begin
        s_next    = s_reg;
        req       = CYC_I & STB_I & ~s_reg.ack;
        wr_req    = req & WE_I & SEL_I[0];
        rd_req    = req & ~WE_I;
        sel       = decode(ADR_I);
        wbyte     = DAT_I[7:0];
        ext_wr_ev = 1'b0;
        ext_rd_ev = 1'b0;
        cpu_rd_in = 1'b0;
        cpu_wr_out = 1'b0;
        rbyte     = `PSP_RST_ZERO8;
        // strobes only count as control inputs in slave port mode
        cs = s_reg.slave_port_enable & ~pins.pe[`PSP_PIN_CS];
        rd = ~pins.pe[`PSP_PIN_RD];
        wr = ~pins.pe[`PSP_PIN_WR];

        // external transfer tracker: an event fires once per strobe assertion
        case (s_reg.xfer)
            psp_pkg::XFER_IDLE: begin
                if (pair_low(cs, wr)) begin
                    s_next.xfer = psp_pkg::XFER_WRITE;
                    ext_wr_ev   = 1'b1;
                end else if (pair_low(cs, rd)) begin
                    s_next.xfer = psp_pkg::XFER_READ;
                    ext_rd_ev   = 1'b1;
                end
            end
            psp_pkg::XFER_WRITE: begin
                if (!pair_low(cs, wr)) begin
                    s_next.xfer = psp_pkg::XFER_IDLE;
                end
            end
            psp_pkg::XFER_READ: begin
                if (!pair_low(cs, rd)) begin
                    s_next.xfer = psp_pkg::XFER_IDLE;
                end
            end
            default: begin
                s_next.xfer = psp_pkg::XFER_IDLE;
            end
        endcase

        // register reads
        rbyte = read_mux(s_reg, pins, sel);
        s_next.ack   = req;
        s_next.rdata = rd_req ? {24'h000000, rbyte} : 32'h00000000;
        cpu_rd_in    = rd_req & (sel == R_PD_PINS) & s_reg.slave_port_enable;

        // register writes; hardware sets below take priority over these clears
        if (wr_req) begin
            case (sel)
                R_PD_PINS: begin
                    s_next.pd_out_latch = wbyte;
                    cpu_wr_out = s_reg.slave_port_enable;
                end
                R_PD_LAT:  s_next.pd_out_latch = wbyte;
                R_PD_DIR:  s_next.pd_dir       = wbyte;
                R_PE_PINS: s_next.pe_out_latch = wbyte;
                R_PE_LAT:  s_next.pe_out_latch = wbyte;
                R_PE_DIR:  s_next.pe_dir       = wbyte;
                R_CTRL: begin
                    s_next.slave_port_enable = wbyte[`PSP_BIT_EN];
                    if (!wbyte[`PSP_BIT_OVR]) begin
                        s_next.input_overrun = 1'b0;
                    end
                end
                R_ADC:     s_next.converter_config_1 = wbyte[5:0];
                R_INTCTL:  s_next.interrupt_control  = wbyte;
                R_IRQ_FLG: s_next.irq_flags   = s_reg.irq_flags & ~wbyte;
                R_IRQ_EN:  s_next.irq_enables = wbyte;
                R_IRQ_PRI: s_next.irq_priority = wbyte;
                default: begin
                end
            endcase
        end

        // flag updates: clear first, set after so a coincident event is kept
        if (cpu_rd_in) begin
            s_next.input_word_pending = 1'b0;
        end
        if (ext_rd_ev) begin
            s_next.output_word_pending = 1'b0;
        end
        if (cpu_wr_out) begin
            s_next.output_word_pending = 1'b1;
        end
        if (ext_wr_ev) begin
            if (s_reg.input_word_pending & ~cpu_rd_in) begin
                s_next.input_overrun = 1'b1;
            end else begin
                // an overrun keeps the unread word; the new one is lost
                s_next.pd_in_latch = pins.pd;
            end
            s_next.input_word_pending = 1'b1;
        end
        if (ext_wr_ev | ext_rd_ev) begin
            s_next.irq_flags[`PSP_BIT_IRQ] = 1'b1;
        end
        if (!s_reg.slave_port_enable) begin
            s_next.xfer = psp_pkg::XFER_IDLE;
        end

        // pins are driven from next state so outputs track the flops directly
        s_next.irq    = |(s_next.irq_flags & s_next.irq_enables);
        s_next.pd_out = s_next.pd_out_latch;
        if (s_next.slave_port_enable) begin
            // data bus driven only during an external read
            s_next.pd_oe_n = (s_next.xfer == psp_pkg::XFER_READ) ? `PSP_ALL_DRIVE8
                                                                 : `PSP_ALL_IN8;
            s_next.pe_oe_n = `PSP_CTRL_IN3;
        end else begin
            s_next.pd_oe_n = s_next.pd_dir;
            s_next.pe_oe_n = s_next.pe_dir[2:0];
        end
        s_next.pe_out  = s_next.pe_out_latch[2:0];
        s_next.ttl_sel = s_next.slave_port_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            s_reg              <= '0;
            s_reg.xfer         <= psp_pkg::XFER_IDLE;
            s_reg.pd_dir       <= `PSP_RST_DIR;
            s_reg.pe_dir       <= `PSP_RST_DIR;
            s_reg.pd_oe_n      <= `PSP_ALL_IN8;
            s_reg.pe_oe_n      <= `PSP_CTRL_IN3;
            s_reg.converter_config_1 <= `PSP_RST_ADC;
            s_reg.irq_priority <= `PSP_RST_PRI;
        end else if (CE) begin
            s_reg <= s_next;
        end
    end

    assign DAT_O      = s_reg.rdata;
    assign ACK_O      = s_reg.ack;
    assign IRQ        = s_reg.irq;
    assign PD_OUT     = s_reg.pd_out;
    assign PD_OE_N    = s_reg.pd_oe_n;
    assign PE_OUT     = s_reg.pe_out;
    assign PE_OE_N    = s_reg.pe_oe_n;
    assign PE_TTL_SEL = s_reg.ttl_sel;

endmodule
`default_nettype wire

// [rtl/psp_cfg.svh]
// constants of the parallel slave port: offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

`define PSP_ADR_W        8
`define PSP_OFS_PD_PINS  8'h00
`define PSP_OFS_PD_LAT   8'h04
`define PSP_OFS_PD_DIR   8'h08
`define PSP_OFS_PE_PINS  8'h0c
`define PSP_OFS_PE_LAT   8'h10
`define PSP_OFS_PE_DIR   8'h14
`define PSP_OFS_CTRL     8'h18
`define PSP_OFS_ADC_CFG  8'h1c
`define PSP_OFS_INTCTL   8'h20
`define PSP_OFS_IRQ_FLG  8'h24
`define PSP_OFS_IRQ_EN   8'h28
`define PSP_OFS_IRQ_PRI  8'h2c

`define PSP_BIT_IBF      7
`define PSP_BIT_OBF      6
`define PSP_BIT_OVR      5
`define PSP_BIT_EN       4
`define PSP_BIT_IRQ      7
`define PSP_PIN_RD       0
`define PSP_PIN_WR       1
`define PSP_PIN_CS       2

`define PSP_RST_DIR      8'hff
`define PSP_RST_PRI      8'h7f
`define PSP_RST_ZERO8    8'h00
`define PSP_RST_ADC      6'h00
`define PSP_RST_PINS     11'h700
`define PSP_ALL_IN8      8'hff
`define PSP_ALL_DRIVE8   8'h00
`define PSP_CTRL_IN3     3'h7

`endif

// [rtl/psp_pin_sync.sv]
// two-flop synchroniser for the port d and port e pins
// assumes pins are asynchronous to SYS_CLK; only the second stage is read
`timescale 1ns/1ps
`default_nettype none
`include "psp_cfg.svh"

module psp_pin_sync (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire psp_pkg::pins_t pins_in,
    output psp_pkg::pins_t     pins_out
);

    psp_pkg::pins_t meta_reg;
    psp_pkg::pins_t sync_reg;

    // strobes idle high after reset so no transfer is seen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= `PSP_RST_PINS;
            sync_reg <= `PSP_RST_PINS;
        end else if (ce) begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
        end
    end

    assign pins_out = sync_reg;

endmodule
`default_nettype wire

// [rtl/psp_pkg.sv]
// types of the parallel slave port
// assumes psp_cfg.svh is not needed here: types only
package psp_pkg;

    typedef enum logic [2:0] {
        XFER_IDLE  = 3'b001,
        XFER_WRITE = 3'b010,
        XFER_READ  = 3'b100
    } xfer_t;

    typedef struct packed {
        logic [2:0] pe;
        logic [7:0] pd;
    } pins_t;

    typedef struct packed {
        xfer_t       xfer;
        logic [7:0]  pd_in_latch;
        logic [7:0]  pd_out_latch;
        logic [7:0]  pd_dir;
        logic [7:0]  pe_out_latch;
        logic [7:0]  pe_dir;
        logic        input_word_pending;
        logic        output_word_pending;
        logic        input_overrun;
        logic        slave_port_enable;
        logic [5:0]  converter_config_1;
        logic [7:0]  interrupt_control;
        logic [7:0]  irq_flags;
        logic [7:0]  irq_enables;
        logic [7:0]  irq_priority;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
        logic [7:0]  pd_out;
        logic [7:0]  pd_oe_n;
        logic [2:0]  pe_out;
        logic [2:0]  pe_oe_n;
        logic        ttl_sel;
    } state_t;

endpackage
